// ==== bccs_pkg.sv ====
package bccs_pkg;

  // APB geometry
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;

  // Register indices; byte address is four times the index
  localparam logic [5:0] REG_IDX_CFG  = 6'h19;
  localparam logic [5:0] REG_IDX_FLAG = 6'h1B;
  localparam logic [5:0] REG_IDX_BIT  = 6'h1C;

  // Configuration register fields
  localparam int unsigned CFG_BASE_LSB   = 10;
  localparam int unsigned CFG_RTHALT_BIT = 4;
  localparam int unsigned CFG_RESP_BIT   = 3;
  localparam int unsigned CFG_TTSYNC_BIT = 2;
  localparam int unsigned CFG_WD_BIT     = 1;
  localparam int unsigned CFG_PINSEL_BIT = 0;

  // Flag port fields
  localparam int unsigned FLAG_CLR_LSB = 8;
  localparam int unsigned FLAG_SET_LSB = 0;

  // Condition register fields
  localparam int unsigned COND_ONE_BIT   = 15;
  localparam int unsigned COND_RETRY_LSB = 13;
  localparam int unsigned COND_BAD_BIT   = 12;
  localparam int unsigned COND_STSET_BIT = 11;
  localparam int unsigned COND_GOOD_BIT  = 10;
  localparam int unsigned COND_FMT_BIT   = 9;
  localparam int unsigned COND_NORSP_BIT = 8;
  localparam int unsigned COND_FLAG_LSB  = 2;
  localparam int unsigned COND_EQ_BIT    = 1;
  localparam int unsigned COND_LT_BIT    = 0;

  // Self-test status fields
  localparam int unsigned BIT_PDONE_BIT = 15;
  localparam int unsigned BIT_PRUN_BIT  = 14;
  localparam int unsigned BIT_PPASS_BIT = 13;
  localparam int unsigned BIT_PABRT_BIT = 12;
  localparam int unsigned BIT_PANY_BIT  = 11;
  localparam int unsigned BIT_RDONE_BIT = 7;
  localparam int unsigned BIT_RRUN_BIT  = 6;
  localparam int unsigned BIT_RPASS_BIT = 5;

  // Reset values
  localparam logic [5:0] CFG_BASE_RST  = 6'h00;
  localparam logic       CFG_BIT_RST   = 1'b0;
  localparam logic [7:0] FLAGS_RST     = 8'h00;
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

  typedef struct packed {
    logic [5:0] memBase;
    logic       rtHaltEn;
    logic       resp1553b;
    logic       timeTagSyncEn;
    logic       watchdogEn;
    logic       pinSel;
  } bccs_cfg_t;

  typedef struct packed {
    logic [1:0] retryCount;
    logic       badMessage;
    logic       statusSet;
    logic       goodBlock;
    logic       formatError;
    logic       noResponse;
  } bccs_msg_t;

  typedef struct packed {
    logic protDone;
    logic protRunning;
    logic protPassed;
    logic protAborted;
    logic ramDone;
    logic ramRunning;
    logic ramPassed;
  } bccs_bist_t;

  typedef struct packed {
    bccs_cfg_t   cfg;
    logic [7:0]  gpFlags;
    logic [31:0] rdata;
    logic        pinOut;
  } bccs_state_t;

endpackage : bccs_pkg

// ==== bccs_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module bccs_regs
  import bccs_pkg::*;
(
  // Clock and reset
  input  wire  logic              ref_clk,
  input  wire  logic              rst_n,
  // APB slave
  input  wire  logic              psel,
  input  wire  logic              penable,
  input  wire  logic              pwrite,
  input  wire  logic [APB_AW-1:0] paddr,
  input  wire  logic [APB_DW-1:0] pwdata,
  input  wire  logic [3:0]        pstrb,
  output logic       [APB_DW-1:0] prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Message sequencer status
  input  wire  logic              ebcOnline,
  input  wire  bccs_msg_t         lastMsg,
  input  wire  logic [7:0]        seqFlagSet,
  input  wire  logic [7:0]        seqFlagClr,
  input  wire  logic              cmpValid,
  input  wire  logic              cmpEqual,
  input  wire  logic              cmpLess,
  // Self-test engines
  input  wire  bccs_bist_t        bistStatus,
  // Shared pin sources
  input  wire  logic              modeCodeReset,
  input  wire  logic              in_command_indicator,
  // Configuration and flag outputs
  output bccs_cfg_t               cfgOut,
  output logic       [7:0]        gpFlags,
  output logic                    sharedPinOut
);

  bccs_state_t s_r;
  bccs_state_t s_nxt;

  logic        setupPhase;
  logic        accessPhase;
  logic        hitCfg;
  logic        hitFlag;
  logic        hitBit;
  logic        hitAny;
  logic        roWrite;
  logic [7:0]  hostSet;
  logic [7:0]  hostClr;
  logic [15:0] cfgWord;
  logic [15:0] condWord;
  logic [15:0] bistWord;
  logic [15:0] readWord;

  // Address decode; low two address bits are ignored
  always_comb begin
    setupPhase  = psel & ~penable;
    accessPhase = psel & penable;
    hitCfg      = (paddr[7:2] == REG_IDX_CFG);
    hitFlag     = (paddr[7:2] == REG_IDX_FLAG);
    hitBit      = (paddr[7:2] == REG_IDX_BIT);
    hitAny      = hitCfg | hitFlag | hitBit;
    roWrite     = pwrite & hitBit;
  end

  // Every access completes with no wait state
  assign pready  = 1'b1;
  assign pslverr = accessPhase & (~hitAny | roWrite);

  // Host set and clear masks honour byte strobes
  always_comb begin
    hostSet = 8'h00;
    hostClr = 8'h00;
    if (accessPhase & pwrite & hitFlag) begin
      if (pstrb[0]) begin
        hostSet = pwdata[FLAG_SET_LSB +: 8];
      end
      if (pstrb[1]) begin
        hostClr = pwdata[FLAG_CLR_LSB +: 8];
      end
    end
  end

  // Configuration read-back; reserved bits 9:5 read zero
  always_comb begin
    cfgWord                        = 16'h0000;
    cfgWord[CFG_BASE_LSB +: 6]     = s_r.cfg.memBase;
    cfgWord[CFG_RTHALT_BIT]        = s_r.cfg.rtHaltEn;
    cfgWord[CFG_RESP_BIT]          = s_r.cfg.resp1553b;
    cfgWord[CFG_TTSYNC_BIT]        = s_r.cfg.timeTagSyncEn;
    cfgWord[CFG_WD_BIT]            = s_r.cfg.watchdogEn;
    cfgWord[CFG_PINSEL_BIT]        = s_r.cfg.pinSel;
  end

  // Condition word
  always_comb begin
    condWord                         = 16'h0000;
    condWord[COND_ONE_BIT]           = 1'b1;
    condWord[COND_RETRY_LSB +: 2]    = lastMsg.retryCount;
    condWord[COND_BAD_BIT]           = lastMsg.badMessage;
    condWord[COND_STSET_BIT]         = lastMsg.statusSet;
    condWord[COND_GOOD_BIT]          = lastMsg.goodBlock;
    condWord[COND_FMT_BIT]           = lastMsg.formatError;
    condWord[COND_NORSP_BIT]         = lastMsg.noResponse;
    condWord[COND_FLAG_LSB +: 6]     = s_r.gpFlags[7:2];
    condWord[COND_EQ_BIT]            = s_r.gpFlags[1];
    condWord[COND_LT_BIT]            = s_r.gpFlags[0];
    // Offline controller hides the whole word, bit 15 included
    if (!ebcOnline) begin
      condWord = 16'h0000;
    end
  end

  // Self-test status word; unlisted bits stay zero
  always_comb begin
    bistWord                  = 16'h0000;
    bistWord[BIT_PDONE_BIT]   = bistStatus.protDone;
    bistWord[BIT_PRUN_BIT]    = bistStatus.protRunning;
    bistWord[BIT_PPASS_BIT]   = bistStatus.protPassed;
    bistWord[BIT_PABRT_BIT]   = bistStatus.protAborted;
    bistWord[BIT_PANY_BIT]    = bistStatus.protDone
                              | bistStatus.protRunning;
    bistWord[BIT_RDONE_BIT]   = bistStatus.ramDone;
    bistWord[BIT_RRUN_BIT]    = bistStatus.ramRunning;
    bistWord[BIT_RPASS_BIT]   = bistStatus.ramPassed;
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    readWord = 16'h0000;
    if (hitCfg) begin
      readWord = cfgWord;
    end else if (hitFlag) begin
      readWord = condWord;
    end else if (hitBit) begin
      readWord = bistWord;
    end
  end

  // Next state
  always_comb begin
    s_nxt = s_r;

    // Configuration write, lane by lane
    if (accessPhase & pwrite & hitCfg) begin
      if (pstrb[0]) begin
        s_nxt.cfg.rtHaltEn      = pwdata[CFG_RTHALT_BIT];
        s_nxt.cfg.resp1553b     = pwdata[CFG_RESP_BIT];
        s_nxt.cfg.timeTagSyncEn = pwdata[CFG_TTSYNC_BIT];
        s_nxt.cfg.watchdogEn    = pwdata[CFG_WD_BIT];
        s_nxt.cfg.pinSel        = pwdata[CFG_PINSEL_BIT];
      end
      if (pstrb[1]) begin
        s_nxt.cfg.memBase = pwdata[CFG_BASE_LSB +: 6];
      end
    end

    // Host flag update: zero bits leave a flag alone, clear beats set
    s_nxt.gpFlags = (s_r.gpFlags | hostSet) & ~hostClr;

    // Sequencer updates land after the host so a hardware set
    // raised in the same cycle as a host clear is kept, unless cmpValid rewrites bits 1:0 in that cycle
    s_nxt.gpFlags = (s_nxt.gpFlags & ~seqFlagClr) | seqFlagSet;
    if (cmpValid) begin
      s_nxt.gpFlags[1] = cmpEqual;
      s_nxt.gpFlags[0] = cmpLess;
    end

    // Read data is captured in the setup phase and held through access
    if (setupPhase) begin
      s_nxt.rdata = {16'h0000, readWord};
      if (pwrite) begin
        s_nxt.rdata = RDATA_RST;
      end
    end

    // Shared pin: 1 selects the in-command indication
    if (s_r.cfg.pinSel) begin
      s_nxt.pinOut = in_command_indicator;
    end else begin
      s_nxt.pinOut = modeCodeReset;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.cfg.memBase       <= CFG_BASE_RST;
      s_r.cfg.rtHaltEn      <= CFG_BIT_RST;
      s_r.cfg.resp1553b     <= CFG_BIT_RST;
      s_r.cfg.timeTagSyncEn <= CFG_BIT_RST;
      s_r.cfg.watchdogEn    <= CFG_BIT_RST;
      s_r.cfg.pinSel        <= CFG_BIT_RST;
      s_r.gpFlags           <= FLAGS_RST;
      s_r.rdata             <= RDATA_RST;
      s_r.pinOut            <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign prdata       = s_r.rdata;
  assign cfgOut       = s_r.cfg;
  assign gpFlags      = s_r.gpFlags;
  assign sharedPinOut = s_r.pinOut;

endmodule : bccs_regs
`default_nettype wire

// ==== bccs_regs_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module bccs_regs_assertions
  import bccs_pkg::*;
(
  // Clock, reset and bus
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [APB_DW-1:0] prdata,
  // Sources and results
  input wire logic              ebcOnline,
  input wire bccs_msg_t         lastMsg,
  input wire logic [7:0]        seqFlagSet,
  input wire logic [7:0]        seqFlagClr,
  input wire logic              cmpValid,
  input wire bccs_bist_t        bistStatus,
  input wire logic              modeCodeReset,
  input wire logic              in_command_indicator,
  input wire bccs_cfg_t         cfgOut,
  input wire logic [7:0]        gpFlags,
  input wire logic              sharedPinOut
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic wrAcc = psel & penable & pwrite & (pstrb[1:0] == 2'h3);
  // Only host-alone writes: sequencer and compare updates outrank the host
  wire logic wrFlag = wrAcc & (paddr[7:2] == REG_IDX_FLAG) & ~|seqFlagSet & ~|seqFlagClr & ~cmpValid;
  wire logic rdSet = psel & ~penable & ~pwrite;
  property p_clear; wrFlag |=> (gpFlags & $past(pwdata[15:8])) == 8'h00; endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_set; wrFlag |=> ($past(pwdata[7:0] & ~pwdata[15:8]) & ~gpFlags) == 8'h00; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_hold; wrFlag |=> ((gpFlags ^ $past(gpFlags)) & ~$past(pwdata[15:8] | pwdata[7:0])) == 8'h00; endproperty
  a_hold: assert property (p_hold) else $error("untouched flag changed");
  property p_cond; rdSet && paddr[7:2] == REG_IDX_FLAG && ebcOnline |=>
    prdata[15:0] == {1'b1, $past(lastMsg), $past(gpFlags)}; endproperty
  a_cond: assert property (p_cond) else $error("condition word wrong");
  property p_off; rdSet && paddr[7:2] == REG_IDX_FLAG && !ebcOnline |=> prdata == 32'h0000_0000; endproperty
  a_off: assert property (p_off) else $error("offline condition not zero");
  property p_bist; rdSet && paddr[7:2] == REG_IDX_BIT |=> prdata[15:0] == {$past(bistStatus[6:3]),
    $past(bistStatus[6] | bistStatus[5]), 3'h0, $past(bistStatus[2:0]), 5'h00}; endproperty
  a_bist: assert property (p_bist) else $error("self-test word wrong");
  property p_cfg; wrAcc && paddr[7:2] == REG_IDX_CFG |=> cfgOut == {$past(pwdata[15:10]), $past(pwdata[4:0])}; endproperty
  a_cfg: assert property (p_cfg) else $error("config not written");
  property p_pin; $past(rst_n) |->
    sharedPinOut == ($past(cfgOut.pinSel) ? $past(in_command_indicator) : $past(modeCodeReset)); endproperty
  a_pin: assert property (p_pin) else $error("shared pin source wrong");
endmodule : bccs_regs_assertions
bind bccs_regs bccs_regs_assertions u_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .ebcOnline, .lastMsg, .seqFlagSet, .seqFlagClr, .cmpValid, .bistStatus, .modeCodeReset,
  .in_command_indicator, .cfgOut, .gpFlags, .sharedPinOut);
`default_nettype wire

// ==== bccs_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module bccs_host
  import bccs_pkg::*;
(
  // Clock
  input  wire logic              ref_clk,
  // APB master side
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic [APB_AW-1:0]      paddr,
  output logic [APB_DW-1:0]      pwdata,
  output logic [3:0]             pstrb,
  input  wire logic [APB_DW-1:0] prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= '0;
  end
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [15:0] d, input logic [3:0] st,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {16'h0000, d};
    pstrb <= st;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle lines scrambled so a slave that ignores psel is caught
    pwdata <= ~pwdata;
    paddr <= ~paddr;
    @(posedge ref_clk);
  endtask : xfer
endmodule : bccs_host
`default_nettype wire

// ==== tb_bc_condition_bit_status_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_bc_condition_bit_status_regs
  import bccs_pkg::*;
;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel, penable, pwrite, pready, pslverr, sharedPinOut, er;
  logic ebcOnline = 1'b1, modeCodeReset = 1'b0, in_command_indicator = 1'b0;
  logic cmpValid = 1'b0, cmpEqual = 1'b0, cmpLess = 1'b0;
  logic [7:0] seqFlagSet = 8'h00, seqFlagClr = 8'h00;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] gpFlags;
  bccs_msg_t lastMsg = '0;
  bccs_bist_t bistStatus = '0;
  bccs_cfg_t cfgOut;
  int errCount = 0, cmpCount = 0;
  bccs_regs uut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .ebcOnline, .lastMsg, .seqFlagSet, .seqFlagClr, .cmpValid, .cmpEqual,
    .cmpLess, .bistStatus, .modeCodeReset, .in_command_indicator, .cfgOut, .gpFlags, .sharedPinOut);
  bccs_host host (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
  initial forever #4 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    if (errCount == 0 && cmpCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [3:0] st, input logic e);
    host.xfer(1'b1, idx, d, st, rd, er);
    chk({31'h0, er}, {31'h0, e});
  endtask : wr
  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp, input logic e);
    host.xfer(1'b0, idx, 16'h0000, 4'h0, rd, er);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, e});
  endtask : rdc
  task automatic t_flags;
    rdc(REG_IDX_FLAG, 32'h0000_8000, 1'b0);
    wr(REG_IDX_FLAG, 16'h00FF, 4'hF, 1'b0);
    rdc(REG_IDX_FLAG, 32'h0000_80FF, 1'b0);
    wr(REG_IDX_FLAG, 16'h0F00, 4'hF, 1'b0);
    rdc(REG_IDX_FLAG, 32'h0000_80F0, 1'b0);
    wr(REG_IDX_FLAG, 16'h8081, 4'hF, 1'b0);
    rdc(REG_IDX_FLAG, 32'h0000_8071, 1'b0);
    wr(REG_IDX_FLAG, 16'h010E, 4'h1, 1'b0);
    rdc(REG_IDX_FLAG, 32'h0000_807F, 1'b0);
  endtask : t_flags
  task automatic t_cond;
    lastMsg <= 7'h55;
    rdc(REG_IDX_FLAG, 32'h0000_D57F, 1'b0);
    lastMsg <= 7'h2A;
    rdc(REG_IDX_FLAG, 32'h0000_AA7F, 1'b0);
    ebcOnline <= 1'b0;
    rdc(REG_IDX_FLAG, 32'h0000_0000, 1'b0);
    ebcOnline <= 1'b1;
  endtask : t_cond
  task automatic t_seq;
    wr(REG_IDX_FLAG, 16'hFF00, 4'hF, 1'b0);
    seqFlagSet <= 8'h80;
    cmpValid   <= 1'b1;
    cmpEqual   <= 1'b1;
    @(posedge ref_clk);
    seqFlagSet <= 8'h00;
    cmpValid   <= 1'b0;
    rdc(REG_IDX_FLAG, 32'h0000_AA82, 1'b0);
    chk({24'h0, gpFlags}, 32'h0000_0082);
    seqFlagClr <= 8'h80;
    cmpValid   <= 1'b1;
    cmpEqual   <= 1'b0;
    cmpLess    <= 1'b1;
    @(posedge ref_clk);
    seqFlagClr <= 8'h00;
    cmpValid   <= 1'b0;
    rdc(REG_IDX_FLAG, 32'h0000_AA01, 1'b0);
    // Hardware set lands on the host clear's access edge and must survive it
    fork
      wr(REG_IDX_FLAG, 16'h8000, 4'hF, 1'b0);
      begin
        @(posedge ref_clk);
        seqFlagSet <= 8'h80;
        @(posedge ref_clk);
        seqFlagSet <= 8'h00;
      end
    join
    rdc(REG_IDX_FLAG, 32'h0000_AA81, 1'b0);
  endtask : t_seq
  task automatic t_bist;
    logic [6:0] b;
    for (int i = 0; i < 7; i++) begin
      b = 7'h01 << i;
      bistStatus <= b;
      rdc(REG_IDX_BIT, {16'h0000, b[6:3], b[6] | b[5], 3'h0, b[2:0], 5'h00}, 1'b0);
    end
    wr(REG_IDX_BIT, 16'hFFFF, 4'hF, 1'b1);
    rdc(6'h00, 32'h0000_0000, 1'b1);
  endtask : t_bist
  task automatic t_cfg;
    rdc(REG_IDX_CFG, 32'h0000_0000, 1'b0);
    wr(REG_IDX_CFG, 16'hFFFF, 4'hF, 1'b0);
    rdc(REG_IDX_CFG, 32'h0000_FC1F, 1'b0);
    chk({21'h0, cfgOut}, 32'h0000_07FF);
    in_command_indicator <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk({31'h0, sharedPinOut}, 32'h0000_0001);
    @(posedge ref_clk);
    wr(REG_IDX_CFG, 16'h0402, 4'hF, 1'b0);
    @(negedge ref_clk);
    chk({21'h0, cfgOut}, 32'h0000_0022);
    chk({31'h0, sharedPinOut}, 32'h0000_0000);
    @(posedge ref_clk);
    modeCodeReset <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk({31'h0, sharedPinOut}, 32'h0000_0001);
    @(posedge ref_clk);
  endtask : t_cfg
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_flags;
    t_cond;
    t_seq;
    t_bist;
    t_cfg;
    results;
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    errCount++;
    results;
  end
endmodule : tb_bc_condition_bit_status_regs
`default_nettype wire
